// >>> acc_adc_ctrl.sv
// Control and result logic of the single 12-bit converter.
//
// Notes on behaviour
// - Each result is 12 unsigned bits from the one routed analog input.
// - A conversion starts only when the start bit is written high, then low.
// - Busy reads 1 from start until the conversion completes, then 0.
// - Enable at 0 powers the converter down; conversions need enable at 1.
// - While disabled, both result registers keep their contents.
// - Format bit picks left or right justification of the 12 result bits.
// - Result bit positions not carrying result bits read as zero.
// - Channel codes 0 to 6 select pins; 7 reserved; 8 to 15 select none.
// - Source 1,2,3 pick bandgap, amplifier 0, amplifier 1; 4 reserved.
// - Reference code 01 uses converter supply; other codes use the pin.
// - Converter clock is the system clock divided by two to the code.
// - Pins set as analog inputs lose other functions and pull-high.
// - Completion of each conversion raises the interrupt request.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module acc_adc_ctrl
  import acc_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic [11:0] CONV_DATA_IN,
  input wire logic [6:0] PIN_ANALOG_IN,
  output logic CONV_POWER_OUT,
  output logic CONV_TICK_OUT,
  output logic CONV_START_OUT,
  output logic [6:0] CHAN_SEL_OUT,
  output logic [2:0] INT_SEL_OUT,
  output logic REF_SUPPLY_OUT,
  output logic [6:0] PIN_ISOLATE_OUT,
  output logic ADC_IRQ_OUT
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  acc_ctl0_t ctl0_r;
  acc_ctl0_t ctl0_nxt;
  acc_ctl1_t ctl1_r;
  acc_ctl1_t ctl1_nxt;
  acc_ctl0_t wr_ctl0_w;
  acc_state_t state_r;
  acc_state_t state_nxt;
  logic [7:0] tick_cnt_r;
  logic [7:0] tick_cnt_nxt;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic [7:0] res_hi_nxt;
  logic [7:0] res_lo_nxt;
  logic [7:0] rdata_r;
  logic start_pulse_r;
  logic irq_r;
  logic [6:0] chan_sel_r;
  logic [2:0] int_sel_r;
  logic ref_supply_r;
  logic [6:0] pin_iso_r;
  wire logic conv_tick_w;
  wire logic wr_ctl0_w_en;
  wire logic wr_ctl1_w_en;
  wire logic start_fall_w;
  wire logic launch_w;
  wire logic st_conv_w;
  wire logic last_tick_w;
  wire logic done_w;
  wire logic abort_w;
  wire logic ext_src_w;
  wire logic [7:0] fmt_hi_w;
  wire logic [7:0] fmt_lo_w;
  wire logic [6:0] chan_sel_nxt;
  wire logic [2:0] int_sel_nxt;
  wire logic [7:0] period_cyc_w;
  wire logic period_ok_w;
  wire logic [7:0] stat_w;
  wire logic [7:0] rd_ctl0_w;
  wire logic [7:0] rdata_nxt;

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  assign wr_ctl0_w_en = WR_IN && (ADDR_IN == ACC_ADDR_CTL0);
  assign wr_ctl1_w_en = WR_IN && (ADDR_IN == ACC_ADDR_CTL1);
  assign wr_ctl0_w = acc_ctl0_t'(WDATA_IN);
  assign ctl0_nxt = wr_ctl0_w_en ? wr_ctl0_w : ctl0_r;
  assign ctl1_nxt = wr_ctl1_w_en ? acc_ctl1_t'(WDATA_IN) : ctl1_r;

  // ****************************************************************
  // Start sequence and conversion sequencing
  // ****************************************************************
  // A start needs the stored start bit at 1 and a write that clears it.
  assign start_fall_w = wr_ctl0_w_en && ctl0_r.start && !wr_ctl0_w.start;
  // The enable written in the same cycle counts, so enabling and
  // dropping start in one write still launches.
  assign launch_w = start_fall_w && wr_ctl0_w.enable &&
                    (state_r == ACC_IDLE);
  assign st_conv_w = (state_r == ACC_CONV);
  assign last_tick_w = conv_tick_w && (tick_cnt_r == ACC_CONV_TICKS - 8'h01);
  assign done_w = st_conv_w && ctl0_r.enable && last_tick_w;
  assign abort_w = st_conv_w && !ctl0_r.enable;

  always_comb
  begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    case (state_r)
      ACC_IDLE:
      begin
        tick_cnt_nxt = 8'h00;
        if (launch_w)
        begin
          state_nxt = ACC_CONV;
        end
      end
      ACC_CONV:
      begin
        if (abort_w || done_w)
        begin
          state_nxt = ACC_IDLE;
          tick_cnt_nxt = 8'h00;
        end
        else if (conv_tick_w)
        begin
          tick_cnt_nxt = tick_cnt_r + 8'h01;
        end
      end
      default:
      begin
        state_nxt = ACC_IDLE;
        tick_cnt_nxt = 8'h00;
      end
    endcase
  end

  // The divider stops on the last tick. With an undivided clock it would
  // otherwise emit one more tick after the conversion has ended.
  acc_clk_div u_clk_div (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .run_in(st_conv_w && ctl0_r.enable && !last_tick_w),
    .sel_in(ctl1_r.ckdiv),
    .tick_out(conv_tick_w)
  );

  // ****************************************************************
  // Result formatting
  // ****************************************************************
  assign fmt_hi_w = ctl0_r.justify ? {4'h0, CONV_DATA_IN[11:8]}
                                   : CONV_DATA_IN[11:4];
  assign fmt_lo_w = ctl0_r.justify ? CONV_DATA_IN[7:0]
                                   : {CONV_DATA_IN[3:0], 4'h0};
  // Both bytes load on the same edge; disabled means no done.
  assign res_hi_nxt = done_w ? fmt_hi_w : res_hi_r;
  assign res_lo_nxt = done_w ? fmt_lo_w : res_lo_r;

  // ****************************************************************
  // Input and reference routing
  // ****************************************************************
  assign ext_src_w = (ctl1_r.src == 3'h0) ||
                     (ctl1_r.src > ACC_SRC_RESERVED);
  // Codes 7 and above connect no pin at all.
  assign chan_sel_nxt = (ctl0_r.enable && ext_src_w &&
                         ctl0_r.chan <= ACC_CH_LAST)
                        ? 7'(7'h01 << ctl0_r.chan[2:0])
                        : 7'h00;
  assign int_sel_nxt = !ctl0_r.enable ? 3'h0 :
                       (ctl1_r.src == ACC_SRC_BANDGAP) ? 3'h1 :
                       (ctl1_r.src == ACC_SRC_AMP0) ? 3'h2 :
                       (ctl1_r.src == ACC_SRC_AMP1) ? 3'h4 : 3'h0;

  // ****************************************************************
  // Read side
  // ****************************************************************
  assign period_cyc_w = 8'h01 << ctl1_r.ckdiv;
  assign period_ok_w = (period_cyc_w >= 8'(ACC_CK_MIN_CYC)) &&
                       (period_cyc_w <= 8'(ACC_CK_MAX_CYC));
  assign stat_w = 8'(period_ok_w) << ACC_STAT_OK_BIT;
  assign rd_ctl0_w = {ctl0_r.start, st_conv_w, ctl0_r.enable,
                      ctl0_r.justify, ctl0_r.chan};
  assign rdata_nxt = !RD_IN ? 8'h00 :
                     (ADDR_IN == ACC_ADDR_RES_HI) ? res_hi_r :
                     (ADDR_IN == ACC_ADDR_RES_LO) ? res_lo_r :
                     (ADDR_IN == ACC_ADDR_CTL0) ? rd_ctl0_w :
                     (ADDR_IN == ACC_ADDR_CTL1) ? ctl1_r :
                     (ADDR_IN == ACC_ADDR_STAT) ? stat_w : 8'h00;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      ctl0_r <= acc_ctl0_t'(ACC_CTL0_RESET);
      ctl1_r <= acc_ctl1_t'(ACC_CTL1_RESET);
      state_r <= ACC_IDLE;
      tick_cnt_r <= 8'h00;
    end
    else
    begin
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      res_hi_r <= ACC_RES_RESET;
      res_lo_r <= ACC_RES_RESET;
      rdata_r <= 8'h00;
    end
    else
    begin
      res_hi_r <= res_hi_nxt;
      res_lo_r <= res_lo_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      start_pulse_r <= 1'b0;
      irq_r <= 1'b0;
      chan_sel_r <= 7'h00;
      int_sel_r <= 3'h0;
      ref_supply_r <= 1'b0;
      pin_iso_r <= 7'h00;
    end
    else
    begin
      start_pulse_r <= launch_w;
      irq_r <= done_w;
      chan_sel_r <= chan_sel_nxt;
      int_sel_r <= int_sel_nxt;
      ref_supply_r <= (ctl1_r.vref == ACC_REF_SUPPLY);
      pin_iso_r <= PIN_ANALOG_IN;
    end
  end

  assign RDATA_OUT = rdata_r;
  assign CONV_POWER_OUT = ctl0_r.enable;
  assign CONV_TICK_OUT = conv_tick_w;
  assign CONV_START_OUT = start_pulse_r;
  assign CHAN_SEL_OUT = chan_sel_r;
  assign INT_SEL_OUT = int_sel_r;
  assign REF_SUPPLY_OUT = ref_supply_r;
  assign PIN_ISOLATE_OUT = pin_iso_r;
  assign ADC_IRQ_OUT = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking acc_cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  property p_launch_needs_fall;
    $rose(st_conv_w) |-> $past(start_fall_w) && CONV_START_OUT;
  endproperty
  a_launch_needs_fall: assert property (p_launch_needs_fall)
    else $error("Conversion began without a start high then low.");

  property p_done_clears_busy;
    done_w |=> !st_conv_w && ADC_IRQ_OUT && rd_ctl0_w[6] == 1'b0;
  endproperty
  a_done_clears_busy: assert property (p_done_clears_busy)
    else $error("Busy or interrupt wrong after completion.");

  property p_disabled_stops;
    !ctl0_r.enable && !launch_w |=>
      !st_conv_w && !CONV_TICK_OUT && !ADC_IRQ_OUT;
  endproperty
  a_disabled_stops: assert property (p_disabled_stops)
    else $error("Conversion kept running while disabled.");

  property p_hold_when_off;
    !ctl0_r.enable |=> $stable(res_hi_r) && $stable(res_lo_r);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off)
    else $error("Result changed while the converter was disabled.");

  property p_left_format;
    done_w && !ctl0_r.justify |=>
      {res_hi_r, res_lo_r} == {$past(CONV_DATA_IN), 4'h0};
  endproperty
  a_left_format: assert property (p_left_format)
    else $error("Left justified result misplaced.");

  property p_right_format;
    done_w && ctl0_r.justify |=>
      {res_hi_r, res_lo_r} == {4'h0, $past(CONV_DATA_IN)};
  endproperty
  a_right_format: assert property (p_right_format)
    else $error("Right justified result misplaced or unused bits set.");

  property p_no_pin_for_high_codes;
    CHAN_SEL_OUT != 7'h00 |->
      $past(ctl0_r.chan) <= ACC_CH_LAST && $onehot(CHAN_SEL_OUT);
  endproperty
  a_no_pin_for_high_codes: assert property (p_no_pin_for_high_codes)
    else $error("External pin selected for an invalid channel code.");

  property p_internal_excludes_pin;
    INT_SEL_OUT != 3'h0 |-> CHAN_SEL_OUT == 7'h00 && $onehot(INT_SEL_OUT);
  endproperty
  a_internal_excludes_pin: assert property (p_internal_excludes_pin)
    else $error("Internal source and external pin routed together.");

  property p_ref_select;
    ##1 REF_SUPPLY_OUT == ($past(ctl1_r.vref) == ACC_REF_SUPPLY);
  endproperty
  a_ref_select: assert property (p_ref_select)
    else $error("Reference selection does not follow its field.");

  property p_ignore_when_busy;
    start_fall_w && st_conv_w |=> !CONV_START_OUT;
  endproperty
  a_ignore_when_busy: assert property (p_ignore_when_busy)
    else $error("Start accepted during a conversion.");

  property p_undivided_ticks;
    st_conv_w && ctl0_r.enable && ctl1_r.ckdiv == 3'h0 ##1
      st_conv_w && $stable(ctl1_r.ckdiv) |-> conv_tick_w;
  endproperty
  a_undivided_ticks: assert property (p_undivided_ticks)
    else $error("Undivided converter clock missed a tick.");

  c_launch: cover property (launch_w);
  c_done_right: cover property (done_w && ctl0_r.justify);
  c_abort: cover property (abort_w);
  c_back_to_back: cover property (done_w ##[1:20] launch_w);

endmodule : acc_adc_ctrl

// >>> acc_pkg.sv
// Package with register map, field layouts and timing of the converter control.
package acc_pkg;

  // ****************************************************************
  // Register indices on the register port
  // ****************************************************************
  localparam logic [2:0] ACC_ADDR_RES_HI = 3'h0;
  localparam logic [2:0] ACC_ADDR_RES_LO = 3'h1;
  localparam logic [2:0] ACC_ADDR_CTL0 = 3'h2;
  localparam logic [2:0] ACC_ADDR_CTL1 = 3'h3;
  localparam logic [2:0] ACC_ADDR_STAT = 3'h4;

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  typedef struct packed {
    logic start;
    logic busy;
    logic enable;
    logic justify;
    logic [3:0] chan;
  } acc_ctl0_t;

  typedef struct packed {
    logic [2:0] src;
    logic [1:0] vref;
    logic [2:0] ckdiv;
  } acc_ctl1_t;

  localparam logic [7:0] ACC_CTL0_RESET = 8'h00;
  localparam logic [7:0] ACC_CTL1_RESET = 8'h00;
  localparam logic [7:0] ACC_RES_RESET = 8'h00;
  localparam int ACC_STAT_OK_BIT = 0;

  // ****************************************************************
  // Input selection codes
  // ****************************************************************
  localparam logic [3:0] ACC_CH_LAST = 4'h6;
  localparam logic [3:0] ACC_CH_RESERVED = 4'h7;
  localparam int ACC_NUM_CH = 7;
  localparam logic [2:0] ACC_SRC_BANDGAP = 3'h1;
  localparam logic [2:0] ACC_SRC_AMP0 = 3'h2;
  localparam logic [2:0] ACC_SRC_AMP1 = 3'h3;
  localparam logic [2:0] ACC_SRC_RESERVED = 3'h4;
  localparam logic [1:0] ACC_REF_SUPPLY = 2'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ACC_SYS_PERIOD_NS = 50;
  localparam int ACC_CK_MIN_NS = 500;
  localparam int ACC_CK_MAX_NS = 10000;
  localparam int ACC_CK_MIN_CYC =
    (ACC_CK_MIN_NS + ACC_SYS_PERIOD_NS - 1) / ACC_SYS_PERIOD_NS;
  localparam int ACC_CK_MAX_CYC = ACC_CK_MAX_NS / ACC_SYS_PERIOD_NS;
  localparam logic [7:0] ACC_CONV_TICKS = 8'h10;

  // ****************************************************************
  // Control states
  // ****************************************************************
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_t;

endpackage : acc_pkg

// >>> acc_clk_div.sv
// Converter clock divider that emits one tick every 2^sel system clocks.
`timescale 1ns/1ps
module acc_clk_div
  import acc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic tick_r;
  wire logic [7:0] span_w;
  wire logic [7:0] mask_w;
  wire logic hit_w;

  // The count restarts whenever the divider stops, so a new conversion
  // always sees a full first period.
  assign span_w = 8'h01 << sel_in;
  assign mask_w = span_w - 8'h01;
  assign hit_w = (cnt_r & mask_w[6:0]) == mask_w[6:0];
  assign cnt_nxt = run_in ? cnt_r + 7'h01 : 7'h00;
  assign tick_out = tick_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 7'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= run_in & hit_w;
    end
  end

endmodule : acc_clk_div

// >>> acc_core_model.sv
// Behavioural model of the analog converter core and its input routing.
`timescale 1ns/1ps
module acc_core_model
  import acc_pkg::*;
(
  input wire logic clk_in,
  input wire logic power_in,
  input wire logic [6:0] chan_sel_in,
  input wire logic [2:0] int_sel_in,
  output logic [11:0] data_out
);
  // ****************************************************************
  // Sample source
  // ****************************************************************
  // Only the routed input reaches the one converter. While unpowered the
  // output toggles, so a stale sample is never taken for a fresh one.
  logic [11:0] sample_r = 12'h000;
  always @(posedge clk_in)
  begin
    if (power_in)
      sample_r <= {2'b10, int_sel_in, chan_sel_in} ^ 12'h35A;
    else
      sample_r <= ~sample_r;
  end
  assign data_out = sample_r;
endmodule : acc_core_model

// >>> testbench.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("Error at %0t ns: got %0h expected %0h", $time, a, b); \
    end \
  end
module testbench
  import acc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [6:0] pin_analog = 7'h00;
  logic [7:0] rdata;
  logic [11:0] conv_data;
  logic power, tick, start, ref_sup, irq;
  logic [6:0] chan_sel, isolate;
  logic [2:0] int_sel;
  int miscompares = 0;
  int n_compared = 0;
  int start_cnt = 0;
  int irq_cnt = 0;
  logic [7:0] d;

  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    if (start === 1'b1)
      start_cnt++;
    if (irq === 1'b1)
      irq_cnt++;
  end

  acc_adc_ctrl acc_adc_ctrl_inst (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
    .RDATA_OUT(rdata), .CONV_DATA_IN(conv_data),
    .PIN_ANALOG_IN(pin_analog), .CONV_POWER_OUT(power),
    .CONV_TICK_OUT(tick), .CONV_START_OUT(start), .CHAN_SEL_OUT(chan_sel),
    .INT_SEL_OUT(int_sel), .REF_SUPPLY_OUT(ref_sup),
    .PIN_ISOLATE_OUT(isolate), .ADC_IRQ_OUT(irq));
  acc_core_model acc_core_model_inst (.clk_in(clk), .power_in(power),
    .chan_sel_in(chan_sel), .int_sel_in(int_sel), .data_out(conv_data));

  // ****************************************************************
  // Bus tasks and helpers
  // ****************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd

  function automatic logic [2:0] int_exp(input logic [2:0] s);
    return (s == 3'h1) ? 3'h1 : (s == 3'h2) ? 3'h2 : (s == 3'h3) ? 3'h4 : 3'h0;
  endfunction : int_exp

  function automatic logic [6:0] ch_exp(input logic [3:0] c);
    return (c < 4'h7) ? (7'h01 << c) : 7'h00;
  endfunction : ch_exp

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    for (int a = 0; a < 6; a++)
    begin
      rd(3'(a), d);
      `CHK(d, 8'h00)
    end
    wr(ACC_ADDR_CTL0, 8'h5F);
    rd(ACC_ADDR_CTL0, d);
    `CHK(d, 8'h1F)
    wr(ACC_ADDR_CTL1, 8'hFF);
    rd(ACC_ADDR_CTL1, d);
    `CHK(d, 8'hFF)
    wr(ACC_ADDR_RES_HI, 8'hFF);
    wr(3'h5, 8'hFF);
    rd(ACC_ADDR_RES_HI, d);
    `CHK(d, 8'h00)
    rd(ACC_ADDR_STAT, d);
    `CHK(d, 8'h01)
    $display("t_regs done");
  endtask : t_regs

  task automatic t_route;
    wr(ACC_ADDR_CTL1, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr(ACC_ADDR_CTL0, {4'h2, 4'(c)});
      settle();
      `CHK(chan_sel, ch_exp(4'(c)))
    end
    wr(ACC_ADDR_CTL0, 8'h28);
    for (int s = 0; s < 8; s++)
    begin
      wr(ACC_ADDR_CTL1, {3'(s), 5'h00});
      settle();
      `CHK(int_sel, int_exp(3'(s)))
    end
    for (int r = 0; r < 4; r++)
    begin
      wr(ACC_ADDR_CTL1, {3'h0, 2'(r), 3'h0});
      settle();
      `CHK(ref_sup, (r == 1))
    end
    `CHK(power, 1'b1)
    @(posedge clk);
    pin_analog <= 7'h55;
    settle();
    `CHK(isolate, 7'h55)
    @(posedge clk);
    pin_analog <= 7'h2A;
    settle();
    `CHK(isolate, 7'h2A)
    $display("t_route done");
  endtask : t_route

  task automatic t_conv(input logic j, input logic [7:0] c1,
                        input logic [3:0] ch);
    logic [11:0] v;
    int gap;
    int n;
    int lim;
    v = {2'b10, int_exp(c1[7:5]), ch_exp(ch)} ^ 12'h35A;
    n = 0;
    gap = 0;
    lim = 0;
    wr(ACC_ADDR_CTL1, c1);
    wr(ACC_ADDR_CTL0, {3'b101, j, ch});
    wr(ACC_ADDR_CTL0, {3'b001, j, ch});
    #1 `CHK(start, 1'b1)
    while (irq !== 1'b1 && lim < 4200)
    begin
      @(posedge clk);
      #1 gap++;
      lim++;
      if (tick === 1'b1)
      begin
        if (n > 0) `CHK(gap, 1 << c1[2:0])
        n++;
        gap = 0;
      end
    end
    `CHK(irq, 1'b1)
    `CHK(n, 16)
    rd(ACC_ADDR_RES_HI, d);
    `CHK(d, j ? {4'h0, v[11:8]} : v[11:4])
    rd(ACC_ADDR_RES_LO, d);
    `CHK(d, j ? v[7:0] : {v[3:0], 4'h0})
    rd(ACC_ADDR_CTL0, d);
    `CHK(d, {3'b001, j, ch})
    $display("t_conv done");
  endtask : t_conv

  task automatic t_refuse;
    logic [7:0] hi;
    int s0;
    int i0;
    wr(ACC_ADDR_CTL1, 8'h03);
    s0 = start_cnt;
    i0 = irq_cnt;
    wr(ACC_ADDR_CTL0, 8'hA5);
    repeat (20) @(posedge clk);
    `CHK(start_cnt, s0)
    wr(ACC_ADDR_CTL0, 8'h25);
    rd(ACC_ADDR_CTL0, d);
    `CHK(d, 8'h65)
    wr(ACC_ADDR_CTL0, 8'hA5);
    wr(ACC_ADDR_CTL0, 8'h25);
    repeat (3000) if (irq_cnt == i0) @(posedge clk);
    `CHK(irq_cnt, i0 + 1)
    `CHK(start_cnt, s0 + 1)
    rd(ACC_ADDR_RES_HI, hi);
    wr(ACC_ADDR_CTL0, 8'hA1);
    wr(ACC_ADDR_CTL0, 8'h21);
    wr(ACC_ADDR_CTL0, 8'h01);
    repeat (300) @(posedge clk);
    `CHK(irq_cnt, i0 + 1)
    rd(ACC_ADDR_RES_HI, d);
    `CHK(d, hi)
    rd(ACC_ADDR_CTL0, d);
    `CHK(d, 8'h01)
    `CHK(power, 1'b0)
    wr(ACC_ADDR_CTL0, 8'h81);
    wr(ACC_ADDR_CTL0, 8'h01);
    repeat (20) @(posedge clk);
    `CHK(start_cnt, s0 + 2)
    $display("t_refuse done");
  endtask : t_refuse

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_route();
    for (int k = 0; k < 8; k++)
      t_conv(k[0], 8'(k), 4'(k % 7));
    t_conv(1'b1, 8'h22, 4'h8);
    t_conv(1'b0, 8'h41, 4'h8);
    t_conv(1'b1, 8'h61, 4'h8);
    t_refuse();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench
